/* File: logic/tpf_top.sv */
`timescale 1ns/10ps
// Summary of operation
// - Firing delay is proportional to the software delay count.
// - Share bit set makes sync B equal to sync A internally.
// - Delay equals count times clock period times prescaler plus one.
// - After the delay, eight firing pulses are emitted.
// - Each half pulse lasts the 16-bit width value in clock cycles.
// - Pulses have equal high and low times.
// - Width changes take effect only after a peripheral reset.
// - Sense bit zero gives active-high pulses, one gives active-low.
// - Interrupt choices: none, A rise, B fall, A both, first pulse.
// - Zero width keeps output inactive but still raises the pulse event.
// - Sources active only while running; interrupt config bits 5..3 select them.
// - Mode bits 3..2: 00 PWM, 01 burst, 1X phase partialization; only 1X is built, 00 and 01 keep the firing engine idle.
// - Source-select bit picks master clock or sync A for the prescaler.
// - Run bit zero stops firing, one starts it.
// - Release bit zero holds the peripheral in reset.
// - Mode register resets to all zeros.
// - Output pin floats while the release bit is zero.
module tpf_top
   import tpf_pkg::*;
(
   // Clock, reset, enable
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   // AXI4-Lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Mains sync pins
   input wire logic zero_cross_sync_a,
   input wire logic zero_cross_sync_b,
   // Firing pin and event
   output logic firing_output,
   output logic firing_output_oe,
   output logic firing_event
);
   typedef struct packed
   {
      logic [7:0] mode;
      logic [7:0] width_hi;
      logic [7:0] width_lo;
      logic [7:0] delay_cnt;
      logic [15:0] prescale;
      logic [7:0] int_cfg;
      logic aw_got;
      logic [7:0] aw_addr;
      logic w_got;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      tpf_state_t state;
      logic [15:0] width_run;
      logic [15:0] pre_cnt;
      logic [7:0] dly_cnt;
      logic [15:0] half_cnt;
      logic [4:0] half_idx;
      logic pulse_on;
      logic fire;
      logic event_q;
      logic [3:0] trains;
   } tpf_state_reg_t;

   tpf_state_reg_t r_q;
   tpf_state_reg_t r_d;

   tpf_sync_if sync_a_if ();
   tpf_sync_if sync_b_if ();

   // Both pins are asynchronous and pass two flip-flops before any edge is seen
   tpf_edge_sync u_sync_a
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .clk_en(clk_en),
      .pin(zero_cross_sync_a),
      .sync(sync_a_if.src)
   );

   tpf_edge_sync u_sync_b
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .clk_en(clk_en),
      .pin(zero_cross_sync_b),
      .sync(sync_b_if.src)
   );

   logic released;
   logic running;
   logic phase_mode;
   logic b_fall;
   logic zero_cross;
   logic pre_tick;
   logic wr_fire;
   logic [7:0] rd_addr;
   logic [2:0] int_sel;
   logic [7:0] wbyte;

   assign released = r_q.mode[POS_RELEASE];
   assign running = released & r_q.mode[POS_RUN];
   assign phase_mode = r_q.mode[POS_MODE_HI];
   // Shared pin: sync B follows sync A, so its fall is sync A's fall
   assign b_fall = r_q.mode[POS_SHARE] ? sync_a_if.fall : sync_b_if.fall;
   assign zero_cross = sync_a_if.rise | b_fall;
   // External prescaler clock counts rising edges of sync A
   assign pre_tick = r_q.mode[POS_SRC_SEL] ? sync_a_if.rise : clk_en;
   // One answer at a time: a new write waits until the last response has left
   assign wr_fire = r_q.aw_got & r_q.w_got & ~r_q.bvalid;
   assign rd_addr = s_axi_araddr;
   assign int_sel = r_q.int_cfg[POS_INT_HI:POS_INT_LO];
   assign wbyte = r_q.w_data[7:0];

   always_comb
   begin
      r_d = r_q;
      // Write address and data are taken in either order
      if (s_axi_awvalid && !r_q.aw_got)
      begin
         r_d.aw_got = 1'b1;
         r_d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !r_q.w_got)
      begin
         r_d.w_got = 1'b1;
         r_d.w_data = s_axi_wdata;
         r_d.w_strb = s_axi_wstrb;
      end
      if (wr_fire)
      begin
         r_d.bvalid = 1'b1;
         r_d.bresp = 2'b00;
         r_d.aw_got = 1'b0;
         r_d.w_got = 1'b0;
         if (r_q.w_strb[0])
         begin
            unique case ({r_q.aw_addr[7:2], 2'b00})
               ADDR_MODE: r_d.mode = wbyte;
               ADDR_WIDTH_HI: r_d.width_hi = wbyte;
               ADDR_WIDTH_LO: r_d.width_lo = wbyte;
               ADDR_DELAY_COUNT: r_d.delay_cnt = wbyte;
               ADDR_PRESCALE: r_d.prescale[7:0] = wbyte;
               ADDR_INT_CONFIG: r_d.int_cfg = wbyte;
               ADDR_STATUS: r_d.bresp = 2'b00;
               default: r_d.bresp = 2'b10;
            endcase
         end
         if (r_q.w_strb[1] && {r_q.aw_addr[7:2], 2'b00} == ADDR_PRESCALE)
         begin
            r_d.prescale[15:8] = r_q.w_data[15:8];
         end
      end
      if (r_q.bvalid && s_axi_bready)
      begin
         r_d.bvalid = 1'b0;
      end
      // Read data are built here and held until rready
      if (s_axi_arvalid && !r_q.rvalid)
      begin
         r_d.rvalid = 1'b1;
         r_d.rresp = 2'b00;
         r_d.rdata = 32'h0000_0000;
         unique case ({rd_addr[7:2], 2'b00})
            ADDR_MODE: r_d.rdata[7:0] = r_q.mode;
            ADDR_WIDTH_HI: r_d.rdata[7:0] = r_q.width_hi;
            ADDR_WIDTH_LO: r_d.rdata[7:0] = r_q.width_lo;
            ADDR_DELAY_COUNT: r_d.rdata[7:0] = r_q.delay_cnt;
            ADDR_PRESCALE: r_d.rdata[15:0] = r_q.prescale;
            ADDR_INT_CONFIG: r_d.rdata[7:0] = r_q.int_cfg;
            // Status: trains started, pulse level, engine state
            ADDR_STATUS: r_d.rdata[7:0] = {r_q.trains, r_q.pulse_on, 1'b0, r_q.state};
            default: r_d.rresp = 2'b10;
         endcase
      end
      else if (r_q.rvalid && s_axi_rready)
      begin
         r_d.rvalid = 1'b0;
      end

      // Firing engine
      r_d.event_q = 1'b0;
      if (!clk_en)
      begin
         // Frozen engine; only the event flag drops, so it never stretches
         r_d.state = r_q.state;
      end
      else if (!released)
      begin
         // Held in reset; width is sampled only here
         r_d.state = ST_IDLE;
         r_d.width_run = {r_q.width_hi, r_q.width_lo};
         r_d.pulse_on = 1'b0;
         r_d.trains = 4'h0;
      end
      else if (!running || !phase_mode)
      begin
         r_d.state = ST_IDLE;
         r_d.pulse_on = 1'b0;
      end
      else
      begin
         // A new crossing restarts the delay even mid-train
         if (zero_cross)
         begin
            r_d.state = ST_DELAY;
            r_d.pre_cnt = 16'h0000;
            r_d.dly_cnt = 8'h00;
            r_d.pulse_on = 1'b0;
         end
         else
         begin
            unique case (r_q.state)
               ST_IDLE: r_d.state = ST_IDLE;
               ST_DELAY:
               begin
                  if (r_q.dly_cnt == r_q.delay_cnt)
                  begin
                     // Delay done: first pulse edge and its event
                     r_d.state = ST_TRAIN;
                     r_d.event_q = 1'b1;
                     r_d.half_cnt = 16'h0001;
                     r_d.half_idx = 5'h01;
                     r_d.pulse_on = (r_q.width_run != 16'h0000);
                     r_d.trains = r_q.trains + 4'h1;
                  end
                  else if (pre_tick)
                  begin
                     if (r_q.pre_cnt == r_q.prescale)
                     begin
                        r_d.pre_cnt = 16'h0000;
                        r_d.dly_cnt = r_q.dly_cnt + 8'h01;
                     end
                     else
                     begin
                        r_d.pre_cnt = r_q.pre_cnt + 16'h0001;
                     end
                  end
               end
               ST_TRAIN:
               begin
                  if (r_q.width_run == 16'h0000)
                  begin
                     // Zero width: the event was raised, no pulse follows
                     r_d.state = ST_IDLE;
                  end
                  else if (r_q.half_cnt == r_q.width_run)
                  begin
                     r_d.half_cnt = 16'h0001;
                     if (r_q.half_idx == HALF_PERIODS)
                     begin
                        // Sixteen halves give eight pulses
                        r_d.state = ST_IDLE;
                        r_d.pulse_on = 1'b0;
                     end
                     else
                     begin
                        r_d.half_idx = r_q.half_idx + 5'h01;
                        r_d.pulse_on = ~r_q.pulse_on;
                     end
                  end
                  else
                  begin
                     r_d.half_cnt = r_q.half_cnt + 16'h0001;
                  end
               end
               default: r_d.state = ST_IDLE;
            endcase
         end
      end
      // Registered pin level; a polarity change still shows in the next cycle
      r_d.fire = r_d.pulse_on ^ r_d.mode[POS_SENSE];
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         // Configuration comes back to the package reset values
         r_q <= '0;
         r_q.mode <= MODE_RESET;
         r_q.width_hi <= WIDTH_HI_RESET;
         r_q.width_lo <= WIDTH_LO_RESET;
         r_q.delay_cnt <= DELAY_RESET;
         r_q.prescale <= PRESCALE_RESET;
         r_q.int_cfg <= INT_CFG_RESET;
         r_q.state <= ST_IDLE;
      end
      else
      begin
         r_q <= r_d;
      end
   end

   // The bus stays live while clk_en is low, so no handshake is ever lost
   assign s_axi_awready = ~r_q.aw_got;
   assign s_axi_wready = ~r_q.w_got;
   assign s_axi_bvalid = r_q.bvalid;
   assign s_axi_bresp = r_q.bresp;
   assign s_axi_arready = ~r_q.rvalid;
   assign s_axi_rvalid = r_q.rvalid;
   assign s_axi_rdata = r_q.rdata;
   assign s_axi_rresp = r_q.rresp;

   assign firing_output = r_q.fire;
   assign firing_output_oe = released;

   always_comb
   begin
      // Sync events are combinational; the first-pulse event comes from a flop
      unique case (int_sel)
         INT_SYNC_A_RISE: firing_event = clk_en & running & sync_a_if.rise;
         INT_SYNC_B_FALL: firing_event = clk_en & running & b_fall;
         INT_SYNC_A_BOTH: firing_event = clk_en & running & (sync_a_if.rise | sync_a_if.fall);
         INT_FIRST_PULSE: firing_event = r_q.event_q;
         default: firing_event = 1'b0;
      endcase
   end
endmodule

/* File: logic/tpf_pkg.sv */
package tpf_pkg;
   // Register byte addresses on the AXI4-Lite slave
   localparam logic [7:0] ADDR_MODE = 8'h00;
   localparam logic [7:0] ADDR_WIDTH_HI = 8'h04;
   localparam logic [7:0] ADDR_WIDTH_LO = 8'h08;
   localparam logic [7:0] ADDR_DELAY_COUNT = 8'h0C;
   localparam logic [7:0] ADDR_PRESCALE = 8'h10;
   localparam logic [7:0] ADDR_INT_CONFIG = 8'h14;
   localparam logic [7:0] ADDR_STATUS = 8'h18;
   // Mode register fields
   localparam int POS_SENSE = 0;
   localparam int POS_MODE_LO = 2;
   localparam int POS_MODE_HI = 3;
   localparam int POS_SRC_SEL = 4;
   localparam int POS_RUN = 5;
   localparam int POS_SHARE = 6;
   localparam int POS_RELEASE = 7;
   // Interrupt configuration field
   localparam int POS_INT_LO = 3;
   localparam int POS_INT_HI = 5;
   // Reset values
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [7:0] WIDTH_HI_RESET = 8'h00;
   localparam logic [7:0] WIDTH_LO_RESET = 8'h00;
   localparam logic [7:0] DELAY_RESET = 8'h00;
   localparam logic [15:0] PRESCALE_RESET = 16'h0000;
   localparam logic [7:0] INT_CFG_RESET = 8'h00;
   // Pulse train
   localparam logic [3:0] PULSE_COUNT = 4'h8;
   localparam logic [4:0] HALF_PERIODS = 5'h10;
   // Interrupt selections
   localparam logic [2:0] INT_NONE = 3'h0;
   localparam logic [2:0] INT_SYNC_A_RISE = 3'h1;
   localparam logic [2:0] INT_SYNC_B_FALL = 3'h2;
   localparam logic [2:0] INT_SYNC_A_BOTH = 3'h3;
   localparam logic [2:0] INT_FIRST_PULSE = 3'h4;
   typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_TRAIN} tpf_state_t;
endpackage

/* File: logic/tpf_sync_if.sv */
`timescale 1ns/10ps
interface tpf_sync_if;
   logic level;
   logic rise;
   logic fall;
   modport src (output level, output rise, output fall);
   modport dst (input level, input rise, input fall);
endinterface

/* File: logic/tpf_edge_sync.sv */
`timescale 1ns/10ps
module tpf_edge_sync
   import tpf_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   // Pin and detected edges
   input wire logic pin,
   tpf_sync_if.src sync
);
   typedef struct packed
   {
      logic s1;
      logic s2;
      logic s3;
   } tpf_esync_t;
   tpf_esync_t r_q;
   tpf_esync_t r_d;
   always_comb
   begin
      r_d = r_q;
      r_d.s1 = pin;
      r_d.s2 = r_q.s1;
      r_d.s3 = r_q.s2;
   end
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         r_q <= '0;
      end
      else if (clk_en)
      begin
         r_q <= r_d;
      end
   end
   // Edges are looked for only after the second stage
   assign sync.level = r_q.s2;
   assign sync.rise = clk_en & r_q.s2 & ~r_q.s3;
   assign sync.fall = clk_en & ~r_q.s2 & r_q.s3;
endmodule

/* File: tb/tpf_mains_model.sv */
`timescale 1ns/10ps
module tpf_mains_model #(parameter int HALF = 200)
(
   // Clock
   input wire logic aclk,
   // Pin B left free
   input wire logic hold_b,
   // Sync pins
   output logic sync_a,
   output logic sync_b
);
   int cnt = 0;
   logic a_q = 1'b0;
   assign sync_a = a_q;
   // A free pin B sits at its pull-up level
   assign sync_b = hold_b ? 1'b1 : a_q;
   always @(posedge aclk)
   begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1)
         a_q <= ~a_q;
   end
endmodule

/* File: tb/tpf_checker.sv */
`timescale 1ns/10ps
module tpf_checker
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Bus
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Firing
   input wire logic firing_output,
   input wire logic firing_output_oe,
   input wire logic firing_event
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
   property p_ar_block;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   a_ar_block: assert property (p_ar_block) else $error("read taken during answer");
   property p_r_answer;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_r_answer: assert property (p_r_answer) else $error("read answer late");
   property p_b_answer;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid;
   endproperty
   a_b_answer: assert property (p_b_answer) else $error("write answer late");
   property p_r_upper;
      s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
   endproperty
   a_r_upper: assert property (p_r_upper) else $error("upper read bits set");
   property p_ev_pulse;
      firing_event |=> !firing_event;
   endproperty
   a_ev_pulse: assert property (p_ev_pulse) else $error("event too long");
   property p_float;
      !firing_output_oe && !$past(firing_output_oe) |-> $stable(firing_output);
   endproperty
   a_float: assert property (p_float) else $error("pulse while floating");
endmodule
bind tpf_top tpf_checker i_tpf_checker (.*);

/* File: tb/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
   import tpf_pkg::*;
   localparam int HALF = 200;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic clk_en = 1'b1;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_awready;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_wready;
   logic [1:0] s_axi_bresp;
   logic s_axi_bvalid;
   logic s_axi_bready = 1'b0;
   logic [7:0] s_axi_araddr = 8'h00;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_rresp;
   logic s_axi_rvalid;
   logic s_axi_rready = 1'b0;
   logic zero_cross_sync_a;
   logic zero_cross_sync_b;
   logic firing_output;
   logic firing_output_oe;
   logic firing_event;
   logic hold_b = 1'b0;
   logic stall = 1'b0;
   logic fo_q = 1'b0;
   logic sa_q = 1'b0;
   logic armed = 1'b0;
   int n_mismatch = 0;
   int check_count = 0;
   int cyc = 0, run = 0, s1 = 0, s2 = 0, n_chg = 0, n_ev = 0, t_a = 0, t_f = 0;
   int dc, de, d1, i;
   int ev_exp[6] = '{0, 1, 1, 2, 2, 0};
   logic [7:0] modes[5] = '{8'hA0, 8'hA4, 8'hAC, 8'h88, 8'hB8};
   int mode_exp[5] = '{0, 0, 32, 0, 0};
   always #5 aclk = ~aclk;
   tpf_mains_model #(.HALF(HALF)) i_tpf_mains_model (.aclk(aclk), .hold_b(hold_b),
      .sync_a(zero_cross_sync_a), .sync_b(zero_cross_sync_b));
   tpf_top i_tpf_top (.*);
   task conclude;
      $display("mismatches %0d, checks %0d", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'b00);
      int k;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (k = 0; k < 40; k++)
      begin
         @(posedge aclk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1)
            break;
      end
      s_axi_bready <= 1'b0;
      if (k == 40)
      begin
         n_mismatch++;
         conclude();
      end
      else
         chk(s_axi_bresp, r);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = 2'b00);
      int k;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (k = 0; k < 40; k++)
      begin
         @(posedge aclk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1)
            break;
      end
      s_axi_rready <= 1'b0;
      if (k == 40)
      begin
         n_mismatch++;
         conclude();
      end
      else
      begin
         chk(s_axi_rresp, r);
         if (r == 2'b00)
            chk(s_axi_rdata, e);
      end
   endtask
   // Stretch lengths and change counts of the firing pin
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      // With stall set, ten frozen cycles fall inside each delay after a rise of A
      clk_en <= !(stall && cyc > t_a + 5 && cyc < t_a + 16);
      fo_q <= firing_output;
      sa_q <= zero_cross_sync_a;
      if (firing_event === 1'b1)
         n_ev <= n_ev + 1;
      run <= (firing_output !== fo_q) ? 1 : run + 1;
      if (firing_output !== fo_q)
      begin
         n_chg <= n_chg + 1;
         s2 <= s1;
         s1 <= run;
         armed <= 1'b0;
         if (armed)
            t_f <= cyc;
      end
      if (zero_cross_sync_a && !sa_q)
      begin
         t_a <= cyc;
         armed <= 1'b1;
      end
   end
   // One mains period from a rise of A; trains end well inside each half
   task automatic meas;
      int k, c0, e0;
      k = 0;
      do
      begin
         @(posedge aclk);
         k++;
      end
      while (!(zero_cross_sync_a && !sa_q) && k < 3 * HALF);
      if (k == 3 * HALF)
      begin
         n_mismatch++;
         conclude();
      end
      c0 = n_chg;
      e0 = n_ev;
      repeat (2 * HALF) @(posedge aclk);
      dc = n_chg - c0;
      de = n_ev - e0;
   endtask
   initial
   begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      for (i = 0; i <= 20; i += 4)
         rd(8'(i), 32'h0);
      rd(8'h1C, 32'h0, 2'b10);
      wr(8'h1C, 32'h0, 2'b10);
      wr(ADDR_WIDTH_LO, 32'h3);
      wr(ADDR_DELAY_COUNT, 32'h4);
      wr(ADDR_PRESCALE, 32'h1);
      wr(ADDR_INT_CONFIG, 32'h20);
      wr(ADDR_MODE, 32'hA8);
      rd(ADDR_MODE, 32'hA8);
      meas;
      chk(dc, 32);
      chk(de, 2);
      chk(s1, 3);
      chk(s2, 3);
      chk(firing_output_oe, 1'b1);
      d1 = t_f - t_a;
      wr(ADDR_DELAY_COUNT, 32'h8);
      meas;
      chk(t_f - t_a - d1, 8);
      d1 = t_f - t_a;
      wr(ADDR_PRESCALE, 32'h3);
      meas;
      chk(t_f - t_a - d1, 16);
      d1 = t_f - t_a;
      stall <= 1'b1;
      meas;
      chk(t_f - t_a - d1, 10);
      stall <= 1'b0;
      wr(ADDR_WIDTH_LO, 32'h5);
      meas;
      chk(s1, 3);
      wr(ADDR_MODE, 32'h0);
      repeat (3) @(posedge aclk);
      chk(firing_output_oe, 1'b0);
      wr(ADDR_MODE, 32'hA8);
      meas;
      chk(s1, 5);
      wr(ADDR_MODE, 32'hA9);
      meas;
      chk(dc, 32);
      chk(firing_output, 1'b1);
      for (i = 0; i < 6; i++)
      begin
         wr(ADDR_INT_CONFIG, 32'(i << 3));
         meas;
         chk(de, ev_exp[i]);
      end
      for (i = 0; i < 5; i++)
      begin
         wr(ADDR_MODE, modes[i]);
         meas;
         chk(dc, mode_exp[i]);
      end
      hold_b <= 1'b1;
      wr(ADDR_MODE, 32'hA8);
      meas;
      chk(dc, 16);
      wr(ADDR_MODE, 32'hE8);
      meas;
      chk(dc, 32);
      hold_b <= 1'b0;
      wr(ADDR_MODE, 32'h0);
      wr(ADDR_WIDTH_LO, 32'h0);
      wr(ADDR_INT_CONFIG, 32'h20);
      wr(ADDR_MODE, 32'hA8);
      meas;
      chk(dc, 0);
      chk(de, 2);
      conclude();
   end
endmodule
